// >>> include/ubc_pkg.sv
// Purpose: Constants and types for the UART buffer-control block.
// Assumes: AXI4-Lite register access, byte offsets below.
// Notes:   Levels run 0..16, hence five bits.
// Contract
// RL1: Write-only control register for 16-byte receive and transmit buffers.
// RL2: Bits 7:6 pick receive trigger 1, 4, 8 or 14 bytes; reset 00.
// RL3: Data-available indication rises once receive fill reaches trigger.
// RL4: Leaving buffered mode keeps buffered bytes until pointers are reset.
// RL5: Software must not toggle buffered mode during active traffic.
// RL6: DMA request lines leave unmasked; interrupt controller masks them.
// RL7: Block DMA mode: transmit request sets at empty, drops at 16 bytes.
// RL8: Block DMA mode: receive request sets at 16 bytes, drops at empty.
// RL9: Single mode: transmit request while empty, receive while nonempty.
// RL10: Bit 0 enables both buffers, resets to 1; other fields reset 0.
// RL11: Software should reset both buffers when switching buffered mode.
// RL12: Writing one to bit 2 or 1 empties transmit or receive buffer.
// RL13: Bit 3 one selects block DMA signalling; zero, the reset, single.
// RL14: Receive-data-available clears on holding read or fill below trigger.
`default_nettype none
package ubc_pkg;
  localparam int        DEPTH      = 16;
  localparam int        PTR_W      = 4;
  localparam int        LVL_W      = 5;
  localparam int        ADDR_W     = 8;
  localparam bit [4:0]  LVL_FULL   = 5'h10;
  localparam bit [4:0]  LVL_ZERO   = 5'h00;
  localparam bit [7:0]  OFF_DATA   = 8'h00;
  localparam bit [7:0]  OFF_BCTL   = 8'h08;
  localparam bit [7:0]  OFF_STAT   = 8'h10;
  localparam bit [7:0]  OFF_MASK   = 8'h14;
  localparam bit [7:0]  OFF_LEVEL  = 8'h18;
  localparam int        BC_EN      = 0;
  localparam int        BC_RXRST   = 1;
  localparam int        BC_TXRST   = 2;
  localparam int        BC_DMA     = 3;
  localparam int        BC_TRIG_LO = 6;
  localparam bit        EN_RST     = 1'b1;
  localparam bit        DMA_RST    = 1'b0;
  localparam bit [1:0]  TRIG_RST   = 2'h0;
  localparam bit [4:0]  TRIG_B0    = 5'h01;
  localparam bit [4:0]  TRIG_B1    = 5'h04;
  localparam bit [4:0]  TRIG_B2    = 5'h08;
  localparam bit [4:0]  TRIG_B3    = 5'h0e;
  localparam int        ST_RXAV    = 0;
  localparam int        ST_OVR     = 1;
  localparam int        ST_TXE     = 2;
  localparam int        ST_W       = 3;
  localparam bit [2:0]  ST_RST     = 3'h0;
  localparam bit [1:0]  RESP_OKAY  = 2'h0;
  localparam bit [1:0]  RESP_SLV   = 2'h2;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } ubc_wr_t;

  function automatic logic [4:0] trig_bytes(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_bytes = TRIG_B0;
      2'h1:    trig_bytes = TRIG_B1;
      2'h2:    trig_bytes = TRIG_B2;
      default: trig_bytes = TRIG_B3;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> rtl/ubc_fifo.sv
// Purpose: 16-byte buffer with pointer reset and single-byte mode.
// Assumes: Caller never pushes when full nor pops when empty.
// Notes:   Flush wins over push and pop in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module ubc_fifo (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      flush,
  input  wire logic                      cap_one,
  input  wire logic                      push,
  input  wire logic [7:0]                push_data,
  input  wire logic                      pop,
  output logic      [7:0]                head,
  output logic      [ubc_pkg::LVL_W-1:0] level,
  output logic                           full,
  output logic                           empty
);
  import ubc_pkg::*;

  logic [7:0]       mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [LVL_W-1:0] lvl_q;

  assign head  = mem_q[rd_q];
  assign level = lvl_q;
  assign empty = (lvl_q == LVL_ZERO);
  // Unbuffered mode holds one byte; old bytes stay until flushed
  assign full  = cap_one ? !empty : (lvl_q == LVL_FULL);

  always_ff @(posedge aclk) begin
    if (push && !flush) begin
      mem_q[wr_q] <= push_data;
    end
  end

  // RL12: pointer reset empties
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      lvl_q <= LVL_ZERO;
    end else begin
      if (push) begin
        wr_q <= wr_q + 4'h1;
      end
      if (pop) begin
        rd_q <= rd_q + 4'h1;
      end
      if (push && !pop) begin
        lvl_q <= lvl_q + 5'h01;
      end else if (pop && !push) begin
        lvl_q <= lvl_q - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ubc_top.sv
// Purpose: Buffer control of a UART: buffers, trigger, DMA request lines.
// Assumes: AXI4-Lite slave on aclk; receiver and serializer on aclk.
// Notes:   Buffer control reads back as zero.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ubc_top (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [ubc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ubc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        rx_in_valid,
  input  wire logic [7:0]                  rx_in_data,
  output logic                             tx_out_valid,
  output logic      [7:0]                  tx_out_data,
  input  wire logic                        tx_out_ready,
  output logic                             rx_data_avail,
  output logic                             tx_dma_request,
  output logic                             rx_dma_request,
  output logic                             irq
);
  import ubc_pkg::*;

  ubc_wr_t          wst_q;
  logic             awrdy_q, wrdy_q, aw_hold_q, w_hold_q, bvalid_q;
  logic [1:0]       bresp_q, rresp_q, trig_q;
  logic [7:0]       awaddr_q, txo_data_q, rx_head, tx_head;
  logic [31:0]      wdata_q, rdata_q;
  logic [3:0]       wstrb_q;
  logic             arrdy_q, rvalid_q, en_q, dma_q, txo_valid_q;
  logic [ST_W-1:0]  stat_q, mask_q, stat_set;
  logic             avail_q, txreq_q, rxreq_q, irq_q, avail_d;
  logic             wr_fire, ar_fire, rd_hold, bc_wr;
  logic             rx_flush, tx_flush, rx_push, tx_push, tx_pop;
  logic [LVL_W-1:0] rx_level, tx_level, thr;
  logic             rx_full, rx_empty, tx_full, tx_empty;

  assign wr_fire  = (wst_q == WR_IDLE) && aw_hold_q && w_hold_q;
  assign ar_fire  = s_axi_arvalid && arrdy_q;
  assign bc_wr    = wr_fire && (awaddr_q == OFF_BCTL) && wstrb_q[0];
  assign rd_hold  = ar_fire && (s_axi_araddr == OFF_DATA) && !rx_empty;
  // RL12: one-cycle pointer resets
  assign rx_flush = bc_wr && wdata_q[BC_RXRST];
  assign tx_flush = bc_wr && wdata_q[BC_TXRST];
  assign rx_push  = rx_in_valid && !rx_full;
  assign tx_push  = wr_fire && (awaddr_q == OFF_DATA) && wstrb_q[0]
                    && !tx_full;
  assign tx_pop   = !tx_empty && (!txo_valid_q || tx_out_ready);
  assign thr      = en_q ? trig_bytes(trig_q) : TRIG_B0;

  // RL1: two 16-byte buffers
  ubc_fifo u_rx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (rx_flush),
    .cap_one   (!en_q),
    .push      (rx_push),
    .push_data (rx_in_data),
    .pop       (rd_hold),
    .head      (rx_head),
    .level     (rx_level),
    .full      (rx_full),
    .empty     (rx_empty)
  );
  ubc_fifo u_tx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (tx_flush),
    .cap_one   (!en_q),
    .push      (tx_push),
    .push_data (wdata_q[7:0]),
    .pop       (tx_pop),
    .head      (tx_head),
    .level     (tx_level),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q     <= WR_IDLE;
      awrdy_q   <= 1'b1;
      wrdy_q    <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awrdy_q) begin
        awaddr_q  <= s_axi_awaddr;
        aw_hold_q <= 1'b1;
        awrdy_q   <= 1'b0;
      end
      if (s_axi_wvalid && wrdy_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_hold_q <= 1'b1;
        wrdy_q   <= 1'b0;
      end
      case (wst_q)
        WR_IDLE: begin
          if (wr_fire) begin
            bvalid_q <= 1'b1;
            wst_q    <= WR_RESP;
            case (awaddr_q)
              OFF_DATA, OFF_BCTL, OFF_STAT, OFF_MASK:
                bresp_q <= RESP_OKAY;
              default: bresp_q <= RESP_SLV;
            endcase
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            bvalid_q  <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awrdy_q   <= 1'b1;
            wrdy_q    <= 1'b1;
            wst_q     <= WR_IDLE;
          end
        end
        default: wst_q <= WR_IDLE;
      endcase
    end
  end

  // RL1: write-only buffer control reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arrdy_q  <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ar_fire) begin
      arrdy_q  <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      case (s_axi_araddr)
        OFF_DATA:  rdata_q <= {24'h000000, rx_empty ? 8'h00 : rx_head};
        OFF_BCTL:  rdata_q <= 32'h0000_0000;
        OFF_STAT:  rdata_q <= {29'h0, stat_q};
        OFF_MASK:  rdata_q <= {29'h0, mask_q};
        OFF_LEVEL: rdata_q <= {11'h0, tx_level, 11'h0, rx_level};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLV;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arrdy_q  <= 1'b1;
    end
  end

  // RL10: buffers enabled at reset
  // RL2: trigger field bits 7:6
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q   <= EN_RST;
      dma_q  <= DMA_RST;
      trig_q <= TRIG_RST;
    end else if (bc_wr) begin
      // RL4: mode change alone keeps bytes
      en_q   <= wdata_q[BC_EN];
      // RL13: DMA signalling select
      dma_q  <= wdata_q[BC_DMA];
      trig_q <= wdata_q[BC_TRIG_LO +: 2];
    end
  end

  // RL3: raise at trigger count
  // RL14: clear on read or below trigger
  assign avail_d = !rd_hold && (rx_level >= thr);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avail_q <= 1'b0;
    end else begin
      avail_q <= avail_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txreq_q <= 1'b0;
      rxreq_q <= 1'b0;
    end else if (dma_q) begin
      // RL7: transmit block request
      if (tx_level == LVL_ZERO) begin
        txreq_q <= 1'b1;
      end else if (tx_level == LVL_FULL) begin
        txreq_q <= 1'b0;
      end
      // RL8: receive block request
      if (rx_level == LVL_FULL) begin
        rxreq_q <= 1'b1;
      end else if (rx_level == LVL_ZERO) begin
        rxreq_q <= 1'b0;
      end
    end else begin
      // RL9: single-byte requests
      txreq_q <= (tx_level == LVL_ZERO);
      rxreq_q <= (rx_level != LVL_ZERO);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txo_valid_q <= 1'b0;
      txo_data_q  <= 8'h00;
    end else if (tx_pop) begin
      txo_valid_q <= 1'b1;
      txo_data_q  <= tx_head;
    end else if (tx_out_ready) begin
      txo_valid_q <= 1'b0;
    end
  end

  // Sticky status, set beats write-one clear
  assign stat_set[ST_RXAV] = avail_d && !avail_q;
  assign stat_set[ST_OVR]  = rx_in_valid && rx_full;
  assign stat_set[ST_TXE]  = tx_pop && (tx_level == 5'h01) && !tx_push;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= ST_RST;
      mask_q <= ST_RST;
      irq_q  <= 1'b0;
    end else begin
      if (wr_fire && awaddr_q == OFF_STAT && wstrb_q[0]) begin
        stat_q <= (stat_q & ~wdata_q[ST_W-1:0]) | stat_set;
      end else begin
        stat_q <= stat_q | stat_set;
      end
      if (wr_fire && awaddr_q == OFF_MASK && wstrb_q[0]) begin
        mask_q <= wdata_q[ST_W-1:0];
      end
      irq_q <= |(stat_q & mask_q);
    end
  end

  // RL6: request lines leave unmasked
  assign tx_dma_request = txreq_q;
  assign rx_dma_request = rxreq_q;
  assign rx_data_avail  = avail_q;
  assign irq            = irq_q;
  assign tx_out_valid   = txo_valid_q;
  assign tx_out_data    = txo_data_q;
  assign s_axi_awready  = awrdy_q;
  assign s_axi_wready   = wrdy_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arrdy_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;

  property p_bc_zero;
    @(posedge aclk) disable iff (!aresetn)
    ar_fire && s_axi_araddr == OFF_BCTL |=> rvalid_q && rdata_q == 32'h0;
  endproperty
  a_bc_zero: assert property (p_bc_zero) // RL1
    else $error("buffer control read not zero");
  property p_rst_val;
    @(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> en_q && !dma_q && trig_q == 2'h0;
  endproperty
  a_rst_val: assert property (p_rst_val) // RL10
    else $error("wrong buffer control reset value");
  property p_trig_bc;
    @(posedge aclk) disable iff (!aresetn)
    bc_wr |=> trig_q == $past(wdata_q[7:6]) && dma_q == $past(wdata_q[3]);
  endproperty
  a_trig_bc: assert property (p_trig_bc) // RL2
    else $error("trigger or DMA field not stored");
  property p_avail_set;
    @(posedge aclk) disable iff (!aresetn)
    rx_level >= thr && !rd_hold |=> avail_q;
  endproperty
  a_avail_set: assert property (p_avail_set) // RL3
    else $error("data available not raised at trigger");
  property p_avail_clr;
    @(posedge aclk) disable iff (!aresetn)
    rd_hold || rx_level < thr |=> !avail_q;
  endproperty
  a_avail_clr: assert property (p_avail_clr) // RL14
    else $error("data available not cleared");
  property p_tx_blk;
    @(posedge aclk) disable iff (!aresetn)
    dma_q && (tx_level == LVL_ZERO || (txreq_q && tx_level != LVL_FULL))
    |=> txreq_q;
  endproperty
  a_tx_blk: assert property (p_tx_blk) // RL7
    else $error("block transmit request dropped early");
  property p_rx_blk;
    @(posedge aclk) disable iff (!aresetn)
    dma_q && (rx_level == LVL_FULL || (rxreq_q && rx_level != LVL_ZERO))
    |=> rxreq_q;
  endproperty
  a_rx_blk: assert property (p_rx_blk) // RL8
    else $error("block receive request dropped early");
  property p_single;
    @(posedge aclk) disable iff (!aresetn)
    !dma_q |=> txreq_q == ($past(tx_level) == LVL_ZERO)
               && rxreq_q == ($past(rx_level) != LVL_ZERO);
  endproperty
  a_single: assert property (p_single) // RL9
    else $error("single-byte request mismatch");
  property p_flush;
    @(posedge aclk) disable iff (!aresetn)
    rx_flush |=> rx_level == LVL_ZERO ##1 !avail_q;
  endproperty
  a_flush: assert property (p_flush) // RL12
    else $error("receive pointer reset failed");
  c_tx_block: cover property (@(posedge aclk) disable iff (!aresetn)
    dma_q && txreq_q ##1 !txreq_q);
  c_trig14: cover property (@(posedge aclk) disable iff (!aresetn)
    trig_q == 2'h3 && $rose(avail_q));
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq_q));
endmodule
`default_nettype wire

// >>> testbench/tb_ubc_top.sv
// Purpose: Self-checking bench for the UART buffer-control block.
// Assumes: Bus responses are always accepted at once (bready, rready high).
// Notes:   Transmit bytes are tracked in a queue and checked on the output.
`timescale 1ns/1ps
`default_nettype none
module tb_ubc_top;
  import ubc_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [7:0]  rx_d = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        arv = 1'b0;
  logic        rxv = 1'b0;
  logic        txr = 1'b0;
  logic        awr, wrdy, bv, arr, rv, txv, rda, txq, rxq, irq;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  logic [7:0]  txd;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          thr [4] = '{1, 4, 8, 14};
  logic [7:0]  q [$];

  ubc_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .rx_in_valid(rxv), .rx_in_data(rx_d),
    .tx_out_valid(txv), .tx_out_data(txd), .tx_out_ready(txr),
    .rx_data_avail(rda), .tx_dma_request(txq), .rx_dma_request(rxq),
    .irq(irq)
  );

  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    chk(br, er);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    araddr <= a;
    arv    <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    chk(rdat, e);
    chk(rr, er);
  endtask

  task automatic push(input logic [7:0] b);
    rx_d <= b;
    rxv  <= 1'b1;
    @(posedge aclk);
    rxv  <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic txw(input logic [7:0] b);
    q.push_back(b);
    wr(OFF_DATA, {24'h0, b}, RESP_OKAY);
  endtask

  task automatic lvl(input logic [4:0] rx, input logic [4:0] tx);
    rdc(OFF_LEVEL, {11'h0, tx, 11'h0, rx}, RESP_OKAY);
  endtask

  // Output byte order and watchdog
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn && txv === 1'b1 && txr === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else chk(txd, q.pop_front());
    end
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    int k;
    int s;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    chk(txq, 1);
    chk(rxq, 0);
    chk(rda, 0);
    chk(irq, 0);
    rdc(OFF_BCTL, 32'h0, RESP_OKAY);
    rdc(OFF_STAT, 32'h0, RESP_OKAY);
    rdc(OFF_MASK, 32'h0, RESP_OKAY);
    push(8'h01);
    push(8'h02);
    lvl(5'd2, 5'd0);
    for (s = 0; s < 4; s++) begin
      wr(OFF_BCTL, 32'(s * 64 + 3), RESP_OKAY);
      lvl(5'd0, 5'd0);
      for (k = 1; k <= 16; k++) begin
        push(8'(k));
        tick(2);
        chk(rda, k >= thr[s]);
      end
    end
    push(8'h11);
    lvl(5'd16, 5'd0);
    rdc(OFF_STAT, 32'h3, RESP_OKAY);
    chk(rxq, 1);
    for (k = 1; k <= 3; k++) begin
      rdc(OFF_DATA, 32'(k), RESP_OKAY);
    end
    tick(2);
    chk(rda, 0);
    wr(OFF_BCTL, 32'hc3, RESP_OKAY);
    tick(2);
    chk(rxq, 0);
    lvl(5'd0, 5'd0);
    wr(OFF_BCTL, 32'h0b, RESP_OKAY);
    for (k = 1; k <= 16; k++) begin
      push(8'(8'h20 + k));
      tick(2);
      chk(rxq, k == 16);
    end
    for (k = 1; k <= 16; k++) begin
      rdc(OFF_DATA, 32'(8'h20 + k), RESP_OKAY);
      tick(2);
      chk(rxq, k < 16);
    end
    chk(txq, 1);
    for (k = 0; k <= 16; k++) begin
      txw(8'(8'h40 + k));
      tick(2);
      chk(txq, k < 16);
    end
    lvl(5'd0, 5'd16);
    txr <= 1'b1;
    tick(4);
    chk(txq, 0);
    k = 0;
    while (txq !== 1'b1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    chk(txq, 1);
    lvl(5'd0, 5'd0);
    tick(2);
    chk(q.size(), 0);
    txr <= 1'b0;
    wr(OFF_BCTL, 32'h05, RESP_OKAY);
    txw(8'h60);
    txw(8'h61);
    tick(2);
    chk(txq, 0);
    lvl(5'd0, 5'd1);
    wr(OFF_BCTL, 32'h05, RESP_OKAY);
    void'(q.pop_back());
    tick(2);
    chk(txq, 1);
    lvl(5'd0, 5'd0);
    txr <= 1'b1;
    tick(4);
    chk(q.size(), 0);
    // Mode change with three receive bytes buffered keeps them, buffers reset afterwards
    wr(OFF_BCTL, 32'h03, RESP_OKAY);
    push(8'h71);
    push(8'h72);
    push(8'h73);
    wr(OFF_BCTL, 32'h00, RESP_OKAY);
    lvl(5'd3, 5'd0);
    rdc(OFF_DATA, 32'h71, RESP_OKAY);
    lvl(5'd2, 5'd0);
    wr(OFF_BCTL, 32'h06, RESP_OKAY);
    lvl(5'd0, 5'd0);
    wr(OFF_BCTL, 32'h07, RESP_OKAY);
    rdc(OFF_STAT, 32'h7, RESP_OKAY);
    wr(OFF_STAT, 32'h7, RESP_OKAY);
    rdc(OFF_STAT, 32'h0, RESP_OKAY);
    wr(OFF_MASK, 32'h1, RESP_OKAY);
    rdc(OFF_MASK, 32'h1, RESP_OKAY);
    push(8'h81);
    tick(3);
    chk(irq, 1);
    wr(OFF_STAT, 32'h1, RESP_OKAY);
    tick(3);
    chk(irq, 0);
    wr(OFF_MASK, 32'h0, RESP_OKAY);
    wr(OFF_BCTL, 32'h03, RESP_OKAY);
    push(8'h82);
    tick(3);
    chk(irq, 0);
    chk(rxq, 1);
    rdc(OFF_STAT, 32'h1, RESP_OKAY);
    rdc(8'h20, 32'h0, RESP_SLV);
    wr(8'h20, 32'h1, RESP_SLV);
    final_report();
  end
endmodule
`default_nettype wire
